// ===== hdl/mfs_manual_feed.sv
`timescale 1ns/1ps
module mfs_manual_feed (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic scan_tick_i,
   input wire mfs_pkg::mfs_mode_t mode_i,
   input wire logic jog_handle_simul_i,
   input wire logic per_rev_jog_valid_i,
   input wire logic feedrate_method_sel_i,
   input wire logic [4:0] feedrate_code_n_i,
   input wire logic feed_unit_sel_lo_i,
   input wire logic feed_unit_sel_hi_i,
   input wire logic [15:0] feedrate_file_reg_lo_i,
   input wire logic [15:0] feedrate_file_reg_hi_i,
   input wire logic [2:0] feed_multiplier_code_i,
   input wire logic rapid_traverse_i,
   input wire logic dry_run_i,
   input wire logic manual_override_valid_i,
   input wire logic external_modal_feed_sel_i,
   input wire logic rapid_linear_sel_i,
   input wire logic [mfs_pkg::NAXIS-1:0] jog_cmd_i,
   input wire logic [mfs_pkg::NAXIS-1:0] handle_req_i,
   input wire logic [mfs_pkg::NAXIS-1:0] axis_moving_i,
   output logic [31:0] feedrate_o,
   output logic per_rev_o,
   output logic use_rapid_o,
   output logic override_en_o,
   output logic simul_mode_o,
   output logic op_error_o,
   output logic [15:0] op_error_code_o,
   output logic [16:0] multiplier_o,
   output logic [mfs_pkg::NAXIS-1:0] jog_run_o,
   output logic [mfs_pkg::NAXIS-1:0] handle_run_o
);
   mfs_pkg::mfs_state_t st_ff;
   mfs_pkg::mfs_state_t nxt_st;

   // Code table in 0.01 steps; per-rev reads the same count as 0.0001 steps
   function automatic logic [31:0] code_feed(input logic [4:0] c);
      logic [31:0] v;
      v = 32'h0;
      case (~c)
         5'h01: v = 32'd100;
         5'h02: v = 32'd140;
         5'h03: v = 32'd200;
         5'h04: v = 32'd270;
         5'h05: v = 32'd370;
         5'h06: v = 32'd520;
         5'h07: v = 32'd720;
         5'h08: v = 32'd1000;
         5'h09: v = 32'd1400;
         5'h0A: v = 32'd2000;
         5'h0B: v = 32'd2700;
         5'h0C: v = 32'd3700;
         5'h0D: v = 32'd5200;
         5'h0E: v = 32'd7200;
         5'h0F: v = 32'd10000;
         5'h10: v = 32'd14000;
         5'h11: v = 32'd20000;
         5'h12: v = 32'd27000;
         5'h13: v = 32'd37000;
         5'h14: v = 32'd52000;
         5'h15: v = 32'd72000;
         5'h16: v = 32'd100000;
         5'h17: v = 32'd140000;
         5'h18: v = 32'd200000;
         5'h19: v = 32'd270000;
         5'h1A: v = 32'd370000;
         5'h1B: v = 32'd520000;
         5'h1C: v = 32'd720000;
         5'h1D: v = 32'd1000000;
         5'h1E: v = 32'd1400000;
         default: v = 32'h0;
      endcase
      return v;
   endfunction : code_feed

   // File register count to 0.01 (per-min) or 0.0001 (per-rev) steps
   function automatic logic [31:0] file_feed(input logic [31:0] cnt, input logic [1:0] inc);
      logic [31:0] v;
      v = cnt;
      case (inc)
         mfs_pkg::INC_10: v = 32'(cnt * 32'd1000);
         mfs_pkg::INC_1: v = 32'(cnt * 32'd100);
         mfs_pkg::INC_0P1: v = 32'(cnt * 32'd10);
         default: v = cnt;
      endcase
      return v;
   endfunction : file_feed

   logic [1:0] inc_sel;
   logic any_mode;
   logic other_mode;
   logic simul;
   logic manual_mode;
   logic [2*mfs_pkg::NAXIS-1:0] ax_next_vec;
   assign inc_sel = {feed_unit_sel_hi_i, feed_unit_sel_lo_i};
   assign manual_mode = mode_i.jog | mode_i.incr | mode_i.ref_ret;
   assign any_mode = |mode_i;
   assign other_mode = mode_i.incr | mode_i.ref_ret | mode_i.handle | mode_i.rand_feed | mode_i.memory;
   assign simul = mode_i.jog & jog_handle_simul_i & ~other_mode;

   // Next state: feed and mode fields on a scan tick, axis states and jog_prev every cycle
   always_comb begin
      nxt_st = st_ff;
      if (scan_tick_i) begin
         if (feedrate_code_n_i != mfs_pkg::CODE_ALL_OFF) begin
            nxt_st.code_hold = feedrate_code_n_i;
         end
         nxt_st.simul = simul;
         nxt_st.use_rapid = rapid_traverse_i & manual_mode;
         nxt_st.override_en = manual_override_valid_i;
         nxt_st.err = jog_handle_simul_i & ~any_mode;
         nxt_st.per_rev = per_rev_jog_valid_i & ~dry_run_i
            & ((manual_mode & ~rapid_traverse_i)
               | (mode_i.rand_feed & ~external_modal_feed_sel_i & rapid_linear_sel_i));
         if (feedrate_method_sel_i) begin
            nxt_st.feed = file_feed({feedrate_file_reg_hi_i, feedrate_file_reg_lo_i}, inc_sel);
         end else if (!rapid_traverse_i && (manual_mode || dry_run_i)) begin
            nxt_st.feed = code_feed(nxt_st.code_hold);
         end
         case (feed_multiplier_code_i[1:0])
            2'h0: nxt_st.mult = 17'd1;
            2'h1: nxt_st.mult = 17'd10;
            2'h2: nxt_st.mult = 17'd100;
            default: nxt_st.mult = 17'd1000;
         endcase
         if (mode_i.incr && feed_multiplier_code_i[2]) begin
            case (feed_multiplier_code_i[1:0])
               2'h0: nxt_st.mult = 17'd5000;
               2'h1: nxt_st.mult = 17'd10000;
               2'h2: nxt_st.mult = 17'd50000;
               default: nxt_st.mult = 17'd100000;
            endcase
         end
      end
      nxt_st.jog_prev = jog_cmd_i;
      // Axis states come from the per-axis arbiters
      for (int i = 0; i < mfs_pkg::NAXIS; i++) begin
         nxt_st.ax[i] = mfs_pkg::mfs_axis_st_t'(ax_next_vec[i*2 +: 2]);
      end
   end

   // Per-axis jog/handle arbitration
   for (genvar a = 0; a < mfs_pkg::NAXIS; a++) begin : g_ax
      logic jog_rise;
      logic handle_ok;
      mfs_pkg::mfs_axis_st_t nxt_ax;
      assign jog_rise = jog_cmd_i[a] & ~st_ff.jog_prev[a];
      assign handle_ok = mode_i.handle | simul;
      always_comb begin
         nxt_ax = st_ff.ax[a];
         case (st_ff.ax[a])
            mfs_pkg::MFS_IDLE: begin
               if (jog_cmd_i[a] && mode_i.jog) begin
                  nxt_ax = mfs_pkg::MFS_JOG;
               end else if (handle_req_i[a] && handle_ok) begin
                  nxt_ax = mfs_pkg::MFS_HANDLE;
               end
            end
            mfs_pkg::MFS_JOG: begin
               if (!jog_cmd_i[a]) begin
                  nxt_ax = mfs_pkg::MFS_WAIT;
               end
            end
            mfs_pkg::MFS_HANDLE: begin
               if (jog_rise && mode_i.jog) begin
                  nxt_ax = mfs_pkg::MFS_WAIT;
               end else if (!handle_req_i[a] || !handle_ok) begin
                  nxt_ax = mfs_pkg::MFS_IDLE;
               end
            end
            mfs_pkg::MFS_WAIT: begin
               if (!axis_moving_i[a]) begin
                  nxt_ax = mfs_pkg::MFS_IDLE;
               end
            end
            default: nxt_ax = mfs_pkg::MFS_IDLE;
         endcase
      end
      assign ax_next_vec[a*2 +: 2] = nxt_ax;
      assign jog_run_o[a] = (st_ff.ax[a] == mfs_pkg::MFS_JOG);
      assign handle_run_o[a] = (st_ff.ax[a] == mfs_pkg::MFS_HANDLE);
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= '{feed: mfs_pkg::FEED_RST, per_rev: 1'b0, use_rapid: 1'b0, override_en: 1'b0, simul: 1'b0,
                    err: 1'b0, code_hold: mfs_pkg::CODE_ALL_OFF, mult: 17'h00001,
                    ax: '{mfs_pkg::NAXIS{mfs_pkg::MFS_IDLE}}, jog_prev: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign feedrate_o = st_ff.feed;
   assign per_rev_o = st_ff.per_rev;
   assign use_rapid_o = st_ff.use_rapid;
   assign override_en_o = st_ff.override_en;
   assign simul_mode_o = st_ff.simul;
   assign op_error_o = st_ff.err;
   assign op_error_code_o = st_ff.err ? mfs_pkg::ERR_NO_MODE : 16'h0000;
   assign multiplier_o = st_ff.mult;

   // Checks
   a_err_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      scan_tick_i && jog_handle_simul_i && !(|mode_i) |=> op_error_o)
      else $error("error not raised");
   a_simul_other: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      scan_tick_i && (mode_i.incr || mode_i.handle) |=> !simul_mode_o)
      else $error("simul with other mode");
   a_dry_permin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      scan_tick_i && dry_run_i |=> !per_rev_o)
      else $error("per-rev in dry run");
   a_per_rev_jog: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      scan_tick_i && per_rev_jog_valid_i && mode_i.jog && !dry_run_i && !rapid_traverse_i |=> per_rev_o)
      else $error("per-rev not taken");
   a_file_scale: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      scan_tick_i && feedrate_method_sel_i && feed_unit_sel_hi_i && feed_unit_sel_lo_i
      |=> feedrate_o == $past({feedrate_file_reg_hi_i, feedrate_file_reg_lo_i}))
      else $error("file feed scale wrong");
   a_ovr_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      scan_tick_i |=> override_en_o == $past(manual_override_valid_i))
      else $error("override enable wrong");
   a_no_both: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (jog_run_o & handle_run_o) == '0)
      else $error("jog and handle on one axis");
   a_hold_scan: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !scan_tick_i |=> $stable(feedrate_o))
      else $error("feed changed off scan");
endmodule : mfs_manual_feed

// ===== hdl/mfs_pkg.sv
// Operation
// - Per-minute increment field: 00=10, 01=1, 10=0.1, 11=0.01 per count.
// - Method select on: program loads binary count in two file registers; device scales.
// - Per-rev valid switches jog, incremental, reference return, qualified random feed to per-rev.
// - Dry run, or rapid in jog/incr/ref modes, keeps per-minute feed.
// - Active-low five-bit code decoded identically for per-minute and per-rev feed.
// - Cutting override applied only while manual override valid is on.
// - Jog mode plus jog-handle bit enters simultaneous mode.
// - Simultaneous mode: rapid on gives rapid feedrate, off gives manual feedrate.
// - Handle feed in jog mode only with simultaneous bit; different axes free.
// - Same axis: jog wins; pending handle starts after jog ends and axis stops.
// - Jog rising on handle-fed axis stops handle; jog starts after axis stops.
// - Jog-handle bit with no operation mode raises error code 0101.
// - Jog-handle bit ignored with any mode other than jog.
// - Multiplication code scales handle pulse travel and incremental shot travel.
// - Method select off uses five-bit code, on uses file registers.
// - All code bits off keeps previous feedrate; cleared at power removal.
// - Code ignored while rapid; applies in jog/incr/ref modes and dry run.
package mfs_pkg;
   localparam int NAXIS = 4;
   // Feedrate in 0.01 unit steps (per-minute), 0.0001 steps per-rev: same integer
   localparam logic [1:0] INC_10 = 2'h0;
   localparam logic [1:0] INC_1 = 2'h1;
   localparam logic [1:0] INC_0P1 = 2'h2;
   localparam logic [1:0] INC_0P01 = 2'h3;
   localparam logic [4:0] CODE_ALL_OFF = 5'h00;
   localparam logic [15:0] ERR_NO_MODE = 16'h0101;
   localparam logic [31:0] FEED_RST = 32'h0;
   typedef enum logic [1:0] {MFS_IDLE, MFS_JOG, MFS_HANDLE, MFS_WAIT} mfs_axis_st_t;
   typedef struct packed {
      logic jog;
      logic incr;
      logic ref_ret;
      logic handle;
      logic rand_feed;
      logic memory;
   } mfs_mode_t;
   typedef struct packed {
      logic [31:0] feed;
      logic per_rev;
      logic use_rapid;
      logic override_en;
      logic simul;
      logic err;
      logic [4:0] code_hold;
      logic [16:0] mult;
      mfs_axis_st_t [NAXIS-1:0] ax;
      logic [NAXIS-1:0] jog_prev;
   } mfs_state_t;
endpackage : mfs_pkg

// ===== tb/manual_feedrate_select_bench.sv
`timescale 1ns/1ps
module manual_feedrate_select_bench;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   mfs_pkg::mfs_mode_t mode = '0;
   logic jog_handle_simul = 1'b0, prv = 1'b0, msel = 1'b0, rt = 1'b0, dry_run = 1'b0, ovr = 1'b0, exf = 1'b0, rls = 1'b0;
   logic [4:0] code = 5'h1F;
   logic [1:0] unit = 2'h0;
   logic [31:0] cnt = 32'h0;
   logic [2:0] mp = 3'h0;
   logic [3:0] jog = 4'h0, hreq = 4'h0, mov, jrun, hrun;
   logic tick, per_rev, rapid, ovr_en, simul, err;
   logic [31:0] feed;
   logic [15:0] ecode;
   logic [16:0] mult;
   int num_errors = 0;
   int checked = 0;
   logic [31:0] step [4] = '{32'h3E8, 32'h64, 32'hA, 32'h1};
   logic [5:0] pr_mode [4] = '{6'h20, 6'h10, 6'h08, 6'h02};
   // Free-running clock
   initial forever #10 clk_i = ~clk_i;
   mfs_seq_model mfs_seq_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(jrun | hrun), .scan_tick_o(tick),
      .axis_moving_o(mov));
   mfs_manual_feed mfs_manual_feed_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .scan_tick_i(tick), .mode_i(mode),
      .jog_handle_simul_i(jog_handle_simul), .per_rev_jog_valid_i(prv), .feedrate_method_sel_i(msel),
      .feedrate_code_n_i(code), .feed_unit_sel_lo_i(unit[0]), .feed_unit_sel_hi_i(unit[1]),
      .feedrate_file_reg_lo_i(cnt[15:0]), .feedrate_file_reg_hi_i(cnt[31:16]), .feed_multiplier_code_i(mp),
      .rapid_traverse_i(rt), .dry_run_i(dry_run), .manual_override_valid_i(ovr), .external_modal_feed_sel_i(exf),
      .rapid_linear_sel_i(rls), .jog_cmd_i(jog), .handle_req_i(hreq), .axis_moving_i(mov), .feedrate_o(feed),
      .per_rev_o(per_rev), .use_rapid_o(rapid), .override_en_o(ovr_en), .simul_mode_o(simul),
      .op_error_o(err), .op_error_code_o(ecode), .multiplier_o(mult), .jog_run_o(jrun), .handle_run_o(hrun));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // Let two scan ticks pass so the outputs reflect the inputs
   task automatic settle();
      int n = 0;
      int k = 0;
      while (k < 2 && n < 50) begin
         @(negedge clk_i);
         n++;
         if (tick === 1'b1) k++;
      end
      if (k < 2) begin
         num_errors++;
         report_and_stop();
      end
      @(negedge clk_i);
   endtask : settle
   task automatic wait_run(input logic h);
      int n = 0;
      while ((h ? hrun[0] : jrun[0]) !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      if ((h ? hrun[0] : jrun[0]) !== 1'b1) begin
         num_errors++;
         report_and_stop();
      end
   endtask : wait_run
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(negedge clk_i);
      cmp(mult, 32'h1);
      @(posedge clk_i);
      mode <= 6'h20;
      code <= 5'h01;
      settle();
      cmp(feed, 32'h155CC0);
      @(posedge clk_i);
      code <= 5'h1E;
      prv <= 1'b1;
      settle();
      cmp(feed, 32'h64);
      @(posedge clk_i);
      code <= 5'h00;
      settle();
      cmp(feed, 32'h64);
      @(posedge clk_i);
      code <= 5'h1F;
      settle();
      cmp(feed, 32'h0);
      done("code");
      for (int p = 0; p < 2; p++) for (int u = 0; u < 4; u++) begin
         @(posedge clk_i);
         cnt <= 32'h0001_0003;
         msel <= 1'b1;
         prv <= p[0];
         unit <= u[1:0];
         settle();
         cmp(feed, 32'h0001_0003 * step[u]);
      end
      done("file");
      @(posedge clk_i);
      msel <= 1'b0;
      rls <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         mode <= pr_mode[i];
         settle();
         cmp(per_rev, 32'h1);
      end
      @(posedge clk_i);
      exf <= 1'b1;
      settle();
      cmp(per_rev, 32'h0);
      @(posedge clk_i);
      mode <= 6'h20;
      dry_run <= 1'b1;
      ovr <= 1'b1;
      settle();
      cmp(per_rev, 32'h0);
      cmp(ovr_en, 32'h1);
      @(posedge clk_i);
      mode <= 6'h10;
      dry_run <= 1'b0;
      rt <= 1'b1;
      ovr <= 1'b0;
      settle();
      cmp(per_rev, 32'h0);
      cmp(ovr_en, 32'h0);
      done("feed mode");
      @(posedge clk_i);
      mode <= 6'h20;
      jog_handle_simul <= 1'b1;
      settle();
      cmp(simul, 32'h1);
      cmp(rapid, 32'h1);
      @(posedge clk_i);
      rt <= 1'b0;
      settle();
      cmp(rapid, 32'h0);
      @(posedge clk_i);
      mode <= 6'h00;
      settle();
      cmp(err, 32'h1);
      cmp(ecode, 32'h0101);
      @(posedge clk_i);
      mode <= 6'h10;
      mp <= 3'h4;
      settle();
      cmp(simul, 32'h0);
      cmp(err, 32'h0);
      cmp(mult, 32'h1388);
      @(posedge clk_i);
      mode <= 6'h04;
      mp <= 3'h6;
      settle();
      cmp(mult, 32'h64);
      done("mode");
      @(posedge clk_i);
      mode <= 6'h20;
      jog_handle_simul <= 1'b0;
      hreq <= 4'h2;
      settle();
      cmp(hrun, 32'h0);
      @(posedge clk_i);
      jog_handle_simul <= 1'b1;
      jog <= 4'h1;
      settle();
      cmp(hrun, 32'h2);
      @(posedge clk_i);
      hreq <= 4'h3;
      settle();
      cmp(jrun, 32'h1);
      cmp(hrun, 32'h2);
      @(posedge clk_i);
      jog <= 4'h0;
      repeat (2) @(negedge clk_i);
      cmp(hrun, 32'h2);
      wait_run(1'b1);
      @(posedge clk_i);
      jog <= 4'h1;
      repeat (3) @(negedge clk_i);
      cmp(hrun[0], 32'h0);
      cmp(jrun[0], 32'h0);
      wait_run(1'b0);
      done("axis");
      report_and_stop();
   end
endmodule : manual_feedrate_select_bench

// ===== tb/mfs_seq_model.sv
`timescale 1ns/1ps
module mfs_seq_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [mfs_pkg::NAXIS-1:0] run_i,
   output logic scan_tick_o,
   output logic [mfs_pkg::NAXIS-1:0] axis_moving_o
);
   logic [1:0] scan_cnt_ff;
   logic [1:0] coast_ff [mfs_pkg::NAXIS];
   // Program scan pulse every fourth cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) scan_cnt_ff <= 2'h0;
      else scan_cnt_ff <= scan_cnt_ff + 2'h1;
   end
   assign scan_tick_o = (scan_cnt_ff == 2'h3);
   // Axis keeps coasting three cycles after its motion command drops
   for (genvar a = 0; a < mfs_pkg::NAXIS; a++) begin : g_ax
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) coast_ff[a] <= 2'h0;
         else if (run_i[a]) coast_ff[a] <= 2'h3;
         else if (coast_ff[a] != 2'h0) coast_ff[a] <= coast_ff[a] - 2'h1;
      end
      assign axis_moving_o[a] = run_i[a] | (coast_ff[a] != 2'h0);
   end
endmodule : mfs_seq_model
